// ==== test/ams_mem_model.sv ====
`timescale 1ns/10ps
module ams_mem_model (
   input wire logic core_clk_i,
   input wire logic [20:0] addr_i,
   input wire logic [1:0] be_n_i,
   input wire logic [3:0] cs_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic [15:0] data_i,
   input wire logic [7:0] wait_len_i,
   output logic [15:0] data_o,
   output logic [3:0] wait_o
);
   // ==========
   // Storage and read drive
   logic [15:0] mem_reg [0:63];
   logic [15:0] last_reg = 16'h0000;
   logic [7:0] wait_cnt_reg = 8'h00;
   logic strobe_n_reg = 1'b1;
   wire logic sel = (cs_n_i != 4'hF);
   wire logic strobe_n = oe_n_i & we_n_i;
   always @(posedge core_clk_i) begin
      if (sel && !we_n_i && !be_n_i[0])
         mem_reg[addr_i[5:0]][7:0] <= data_i[7:0];
      if (sel && !we_n_i && !be_n_i[1])
         mem_reg[addr_i[5:0]][15:8] <= data_i[15:8];
      if (sel && !oe_n_i)
         last_reg <= mem_reg[addr_i[5:0]];
   end
   // Released bus shows the inverse of the last word so a stale value never passes
   assign data_o = (sel && !oe_n_i) ? mem_reg[addr_i[5:0]] : ~last_reg;
   // ==========
   // Slow device: wait raised one cycle after strobe start, for a commanded length
   always @(posedge core_clk_i) begin
      strobe_n_reg <= strobe_n;
      if (strobe_n_reg && !strobe_n && sel)
         wait_cnt_reg <= wait_len_i;
      else if (wait_cnt_reg != 8'h00)
         wait_cnt_reg <= wait_cnt_reg - 8'h01;
   end
   assign wait_o = {1'b0, wait_cnt_reg != 8'h00, 2'h0};
endmodule // ams_mem_model

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   // ==========
   // Stimulus, configuration and wiring
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic valid = 1'b0;
   logic wr = 1'b0;
   logic [1:0] space = 2'h0;
   logic [20:0] addr = 21'h000000;
   logic [1:0] bank = 2'h0;
   logic [1:0] be_n = 2'h0;
   logic [15:0] wdata = 16'h0000;
   logic [1:0] beats = 2'h0;
   logic [3:0] ss = 4'h2;
   logic [3:0] ew = 4'h8;
   logic [3:0][1:0] ta = 8'h20;
   logic [3:0][3:0] setup_f = 16'h1111;
   logic [3:0][5:0] strobe_f = {6'h05, 6'h02, 6'h02, 6'h02};
   // Write strobes of spaces 0 to 2 differ from read strobes so a swapped timing set is caught
   logic [3:0][5:0] wstrobe_f = {6'h05, 6'h03, 6'h03, 6'h03};
   logic [3:0][2:0] hold_f = 12'h249;
   logic [7:0] max_ext_wait_field = 8'h00;
   logic [7:0] wait_len = 8'h00;
   logic take, done, abort, rd_valid, tmo, busy, doe, dir, we_n, oe_n;
   logic [15:0] rd_data, dout, mrd, din;
   logic [20:0] maddr;
   logic [1:0] mbank, mbe;
   logic [3:0] cs_n, mwait;
   assign din = doe ? dout : mrd;
   ams_sequencer i_dut (.core_clk_i(clk), .rst_i(rst), .req_valid_i(valid), .req_write_i(wr),
      .req_space_i(space), .req_addr_i(addr), .req_bank_i(bank), .req_be_n_i(be_n),
      .req_wdata_i(wdata), .req_beats_i(beats), .req_take_o(take), .req_done_o(done),
      .req_abort_o(abort), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .timeout_o(tmo),
      .busy_o(busy), .cfg_select_strobe_i(ss), .cfg_ext_wait_en_i(ew), .cfg_turnaround_count_i(ta),
      .cfg_r_setup_i(setup_f), .cfg_r_strobe_i(strobe_f), .cfg_r_hold_i(hold_f),
      .cfg_w_setup_i(setup_f), .cfg_w_strobe_i(wstrobe_f), .cfg_w_hold_i(hold_f),
      .max_ext_wait_field_i(max_ext_wait_field), .mem_address_out_o(maddr), .mem_bank_address_out_o(mbank),
      .mem_byte_enable_n_o(mbe), .mem_data_bus_i(din), .mem_data_bus_o(dout),
      .mem_data_bus_oe_o(doe), .mem_direction_o(dir), .mem_chip_select_n_o(cs_n),
      .mem_write_enable_n_o(we_n), .mem_output_enable_n_o(oe_n), .mem_wait_in_i(mwait));
   ams_mem_model i_mem (.core_clk_i(clk), .addr_i(maddr), .be_n_i(mbe), .cs_n_i(cs_n),
      .we_n_i(we_n), .oe_n_i(oe_n), .data_i(dout), .wait_len_i(wait_len), .data_o(mrd),
      .wait_o(mwait));
   initial begin
      forever #12.5 clk = ~clk;
   end
   // ==========
   // Pin monitor
   int cyc = 0, done_cyc = 0, tk_cyc = 0, st_cyc = 0, fail_count = 0, num_checks = 0;
   int cs_lo = 0, oe_lo = 0, we_lo = 0, dir_lo = 0, ab_seen = 0, to_seen = 0;
   int gq[$];
   logic [15:0] rq[$];
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cs_n != 4'hF) cs_lo <= cs_lo + 1;
      if (!oe_n) oe_lo <= oe_lo + 1;
      if (!we_n) we_lo <= we_lo + 1;
      if (!dir) dir_lo <= dir_lo + 1;
      if (abort) ab_seen <= ab_seen + 1;
      if (tmo) to_seen <= to_seen + 1;
      if (done) done_cyc <= cyc;
      if (take) tk_cyc <= cyc;
      // Gap from the last hold cycle of one request to the take of the next
      if (take) gq.push_back(done ? 0 : cyc - done_cyc);
      if (rd_valid) rq.push_back(rd_data);
      if (cyc == 6000) begin
         fail_count++;
         give_verdict();
      end
   end
   // ==========
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic clr(input string name);
      $display("test %s done", name);
      @(negedge clk);
      {cs_lo, oe_lo, we_lo, dir_lo, ab_seen, to_seen} = '0;
      gq.delete();
      rq.delete();
      @(posedge clk);
   endtask
   // Called at a rising edge; keep leaves the request raised for a following one
   task automatic start(input logic w, input logic [1:0] sp, input logic [20:0] a,
                        input logic [15:0] d, input logic [1:0] nb, input bit keep);
      int n;
      st_cyc = cyc;
      valid <= 1'b1;
      wr <= w;
      space <= sp;
      addr <= a;
      bank <= sp;
      wdata <= d;
      beats <= nb;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (take !== 1'b1 && n < 50);
      if (n == 50) chk(0, 1);
      if (!keep) begin
         valid <= 1'b0;
         wdata <= d + 16'h0101;
      end
   endtask
   task automatic wdone;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'b1 && n < 200);
      if (n == 200) chk(0, 1);
      repeat (4) @(posedge clk);
   endtask
   task automatic op(input logic w, input logic [1:0] sp, input logic [20:0] a,
                     input logic [15:0] d, input logic [1:0] nb);
      start(w, sp, a, d, nb, 1'b0);
      wdone();
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ==========
   // Tests
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({cs_n, we_n, oe_n, dir, mbe}, {4'hF, 1'b1, 1'b1, 1'b1, 2'h3});
      clr("reset");
      op(1'b1, 2'h0, 21'h000004, 16'hA5C3, 2'h0);
      chk(we_lo, 4);
      chk(dir_lo, 8);
      chk(cs_lo, 8);
      chk(oe_lo, 0);
      clr("normal write");
      op(1'b0, 2'h0, 21'h000004, 16'h0000, 2'h0);
      chk(rq[0], 16'hA5C3);
      chk(oe_lo, 3);
      chk(cs_lo, 7);
      chk(we_lo + dir_lo, 0);
      clr("normal read");
      op(1'b1, 2'h1, 21'h000008, 16'h1234, 2'h0);
      chk(cs_lo, 4);
      chk(we_lo, 4);
      chk({maddr, mbank, busy}, {21'h000008, 2'h1, 1'b0});
      clr("strobe select write");
      op(1'b0, 2'h1, 21'h000008, 16'h0000, 2'h0);
      chk(cs_lo, 3);
      chk(rq[0], 16'h1234);
      chk(oe_lo, 3);
      clr("strobe select read");
      op(1'b1, 2'h0, 21'h000010, 16'h5A00, 2'h1);
      chk(cs_lo, 16);
      chk(dir_lo, 16);
      chk(we_lo, 8);
      clr("two beat write");
      op(1'b0, 2'h0, 21'h000010, 16'h0000, 2'h1);
      chk(rq.size(), 2);
      chk(rq[0], 16'h5A00);
      chk(rq[1], 16'h5B01);
      chk(cs_lo, 14);
      clr("two beat read");
      start(1'b1, 2'h0, 21'h000020, 16'h0F0F, 2'h0, 1'b1);
      start(1'b0, 2'h0, 21'h000020, 16'h0000, 2'h0, 1'b1);
      start(1'b0, 2'h0, 21'h000004, 16'h0000, 2'h0, 1'b1);
      start(1'b1, 2'h0, 21'h000021, 16'hF0F0, 2'h0, 1'b0);
      wdone();
      chk(gq[1], 1);
      chk(gq[2], 0);
      chk(gq[3], 1);
      chk(rq[0], 16'h0F0F);
      chk(rq[1], 16'hA5C3);
      clr("back to back");
      op(1'b0, 2'h2, 21'h000004, 16'h0000, 2'h0);
      chk(tk_cyc - st_cyc, 3);
      chk(rq[0], 16'hA5C3);
      clr("turnaround");
      valid <= 1'b1;
      wr <= 1'b0;
      space <= 2'h2;
      @(posedge clk);
      valid <= 1'b0;
      repeat (6) @(posedge clk);
      chk(ab_seen, 1);
      chk(cs_lo, 0);
      clr("abandon");
      wait_len <= 8'h06;
      op(1'b0, 2'h3, 21'h000004, 16'h0000, 2'h0);
      chk(oe_lo > 6, 1);
      chk(rq[0], 16'hA5C3);
      clr("read wait");
      op(1'b1, 2'h3, 21'h000005, 16'h7E7E, 2'h0);
      chk(we_lo > 6, 1);
      clr("write wait");
      wait_len <= 8'h28;
      op(1'b0, 2'h3, 21'h000004, 16'h0000, 2'h0);
      chk(to_seen, 1);
      chk(oe_lo > 16, 1);
      wait_len <= 8'h00;
      repeat (40) @(posedge clk);
      clr("wait timeout");
      give_verdict();
   end
endmodule // tb_top

// ==== verilog/ams_pkg.sv ====
package ams_pkg;
   localparam int ADDR_W = 21;
   localparam int BANK_W = 2;
   localparam int DATA_W = 16;
   localparam int BE_W = 2;
   localparam int SPACES = 4;
   localparam int WAIT_W = 4;
   localparam int SETUP_W = 4;
   localparam int STROBE_W = 6;
   localparam int HOLD_W = 3;
   localparam int TA_W = 2;
   localparam int MAX_EXT_WAIT_FIELD_W = 8;
   localparam int BEATS_W = 2;
   localparam int CNT_W = 6;
   localparam int WCNT_W = 13;
   localparam int WAIT_UNIT_SHIFT = 4;
   localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
   localparam logic [WCNT_W-1:0] WCNT_RESET = 13'h0000;
   localparam logic [CNT_W-1:0] TA_DIR_CHANGE = 6'h01;

   typedef enum logic [2:0] {
      AMS_IDLE = 3'h0,
      AMS_TURN = 3'h1,
      AMS_SETUP = 3'h3,
      AMS_STROBE = 3'h2,
      AMS_HOLD = 3'h6
   } ams_state_t;
endpackage

// ==== verilog/ams_sequencer.sv ====
`timescale 1ns/10ps
module ams_sequencer #(
   parameter int SPACES = 4
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [1:0] req_space_i,
   input wire logic [ams_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic [ams_pkg::BANK_W-1:0] req_bank_i,
   input wire logic [ams_pkg::BE_W-1:0] req_be_n_i,
   input wire logic [ams_pkg::DATA_W-1:0] req_wdata_i,
   input wire logic [ams_pkg::BEATS_W-1:0] req_beats_i,
   output logic req_take_o,
   output logic req_done_o,
   output logic req_abort_o,
   output logic [ams_pkg::DATA_W-1:0] rd_data_o,
   output logic rd_valid_o,
   output logic timeout_o,
   output logic busy_o,
   input wire logic [SPACES-1:0] cfg_select_strobe_i,
   input wire logic [SPACES-1:0] cfg_ext_wait_en_i,
   input wire logic [SPACES-1:0][ams_pkg::TA_W-1:0] cfg_turnaround_count_i,
   input wire logic [SPACES-1:0][ams_pkg::SETUP_W-1:0] cfg_r_setup_i,
   input wire logic [SPACES-1:0][ams_pkg::STROBE_W-1:0] cfg_r_strobe_i,
   input wire logic [SPACES-1:0][ams_pkg::HOLD_W-1:0] cfg_r_hold_i,
   input wire logic [SPACES-1:0][ams_pkg::SETUP_W-1:0] cfg_w_setup_i,
   input wire logic [SPACES-1:0][ams_pkg::STROBE_W-1:0] cfg_w_strobe_i,
   input wire logic [SPACES-1:0][ams_pkg::HOLD_W-1:0] cfg_w_hold_i,
   input wire logic [ams_pkg::MAX_EXT_WAIT_FIELD_W-1:0] max_ext_wait_field_i,
   output logic [ams_pkg::ADDR_W-1:0] mem_address_out_o,
   output logic [ams_pkg::BANK_W-1:0] mem_bank_address_out_o,
   output logic [ams_pkg::BE_W-1:0] mem_byte_enable_n_o,
   input wire logic [ams_pkg::DATA_W-1:0] mem_data_bus_i,
   output logic [ams_pkg::DATA_W-1:0] mem_data_bus_o,
   output logic mem_data_bus_oe_o,
   output logic mem_direction_o,
   output logic [SPACES-1:0] mem_chip_select_n_o,
   output logic mem_write_enable_n_o,
   output logic mem_output_enable_n_o,
   input wire logic [ams_pkg::WAIT_W-1:0] mem_wait_in_i
);

   // ==========================================================
   // Declarations
   ams_pkg::ams_state_t state_reg, state_next;
   logic [ams_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic [ams_pkg::SETUP_W-1:0] setup_reg;
   logic [ams_pkg::STROBE_W-1:0] strobe_reg;
   logic [ams_pkg::HOLD_W-1:0] hold_reg;
   logic [ams_pkg::BEATS_W-1:0] beats_reg;
   logic [1:0] space_reg;
   logic write_reg, ss_reg, ew_reg;
   logic [ams_pkg::WCNT_W-1:0] wcnt_reg, wait_limit;
   logic [ams_pkg::WAIT_W-1:0] wait_s1_reg, wait_s2_reg;
   logic [ams_pkg::DATA_W-1:0] capture_reg;
   logic capture_valid_reg;
   logic take_first, take_next, strobe_end, timeout_hit, waiting;
   logic [ams_pkg::CNT_W-1:0] ta_eff;
   logic write_next, ss_next, in_cycle_next;
   logic [1:0] space_next;

   // ==========================================================
   // Wait input synchroniser
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wait_s1_reg <= '0;
         wait_s2_reg <= '0;
      end else begin
         wait_s1_reg <= mem_wait_in_i;
         wait_s2_reg <= wait_s1_reg;
      end
   end

   // Timeout limit is (field + 1) * 16 interface clocks
   assign wait_limit = (ams_pkg::WCNT_W'(max_ext_wait_field_i) + 13'h0001) << ams_pkg::WAIT_UNIT_SHIFT;
   assign waiting = ew_reg && (|wait_s2_reg);
   assign timeout_hit = (wcnt_reg >= wait_limit);

   // ==========================================================
   // Turnaround selection
   always_comb begin
      ta_eff = ams_pkg::CNT_W'(cfg_turnaround_count_i[req_space_i]);
      if (state_reg == ams_pkg::AMS_HOLD) begin
         // Back to back with the access just finishing
         if (write_reg == req_write_i) begin
            ta_eff = ams_pkg::CNT_RESET;
         end else if (cfg_turnaround_count_i[req_space_i] == '0) begin
            ta_eff = ams_pkg::TA_DIR_CHANGE;
         end
      end
   end

   // ==========================================================
   // Sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      take_first = 1'b0;
      take_next = 1'b0;
      strobe_end = 1'b0;
      req_done_o = 1'b0;
      req_abort_o = 1'b0;
      case (state_reg)
         ams_pkg::AMS_IDLE: begin
            if (req_valid_i) begin
               if (ta_eff == '0) begin
                  state_next = ams_pkg::AMS_SETUP;
                  take_first = 1'b1;
               end else begin
                  state_next = ams_pkg::AMS_TURN;
                  cnt_next = ta_eff - 6'h01;
               end
            end
         end
         ams_pkg::AMS_TURN: begin
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 6'h01;
            end else if (req_valid_i) begin
               state_next = ams_pkg::AMS_SETUP;
               take_first = 1'b1;
            end else begin
               state_next = ams_pkg::AMS_IDLE;
               req_abort_o = 1'b1;
            end
         end
         ams_pkg::AMS_SETUP: begin
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 6'h01;
            end else begin
               state_next = ams_pkg::AMS_STROBE;
               cnt_next = ams_pkg::CNT_W'(strobe_reg);
            end
         end
         ams_pkg::AMS_STROBE: begin
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 6'h01;
            end else if (waiting && !timeout_hit) begin
               cnt_next = cnt_reg;
            end else begin
               state_next = ams_pkg::AMS_HOLD;
               strobe_end = 1'b1;
               cnt_next = ams_pkg::CNT_W'(hold_reg);
            end
         end
         ams_pkg::AMS_HOLD: begin
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 6'h01;
            end else if (beats_reg != '0) begin
               // Narrow device: straight back to setup, counts untouched
               state_next = ams_pkg::AMS_SETUP;
               take_next = 1'b1;
               cnt_next = ams_pkg::CNT_W'(setup_reg);
            end else begin
               req_done_o = 1'b1;
               if (req_valid_i) begin
                  if (ta_eff == '0) begin
                     state_next = ams_pkg::AMS_SETUP;
                     take_first = 1'b1;
                  end else begin
                     state_next = ams_pkg::AMS_TURN;
                     cnt_next = ta_eff - 6'h01;
                  end
               end else begin
                  state_next = ams_pkg::AMS_IDLE;
               end
            end
         end
         default: begin
            state_next = ams_pkg::AMS_IDLE;
            cnt_next = ams_pkg::CNT_RESET;
         end
      endcase
      if (take_first) begin
         cnt_next = req_write_i ? ams_pkg::CNT_W'(cfg_w_setup_i[req_space_i])
                                : ams_pkg::CNT_W'(cfg_r_setup_i[req_space_i]);
      end
   end

   assign req_take_o = take_first;
   assign busy_o = (state_reg != ams_pkg::AMS_IDLE);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg <= ams_pkg::AMS_IDLE;
         cnt_reg <= ams_pkg::CNT_RESET;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // ==========================================================
   // Request capture and timing counts
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         setup_reg <= '0;
         strobe_reg <= '0;
         hold_reg <= '0;
         beats_reg <= '0;
         space_reg <= 2'h0;
         write_reg <= 1'b0;
         ss_reg <= 1'b0;
         ew_reg <= 1'b0;
      end else if (take_first) begin
         // Counts are loaded once per request so later beats reuse them
         if (req_write_i) begin
            setup_reg <= cfg_w_setup_i[req_space_i];
            strobe_reg <= cfg_w_strobe_i[req_space_i];
            hold_reg <= cfg_w_hold_i[req_space_i];
         end else begin
            setup_reg <= cfg_r_setup_i[req_space_i];
            strobe_reg <= cfg_r_strobe_i[req_space_i];
            hold_reg <= cfg_r_hold_i[req_space_i];
         end
         beats_reg <= req_beats_i;
         space_reg <= req_space_i;
         write_reg <= req_write_i;
         ss_reg <= cfg_select_strobe_i[req_space_i];
         ew_reg <= cfg_ext_wait_en_i[req_space_i];
      end else if (take_next) begin
         beats_reg <= beats_reg - 2'h1;
      end
   end

   // ==========================================================
   // Extended wait counter
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wcnt_reg <= ams_pkg::WCNT_RESET;
         timeout_o <= 1'b0;
      end else begin
         timeout_o <= strobe_end && waiting;
         if (state_reg == ams_pkg::AMS_STROBE && cnt_reg == '0 && waiting) begin
            wcnt_reg <= wcnt_reg + 13'h0001;
         end else begin
            wcnt_reg <= ams_pkg::WCNT_RESET;
         end
      end
   end

   // ==========================================================
   // Memory pins
   assign write_next = take_first ? req_write_i : write_reg;
   assign ss_next = take_first ? cfg_select_strobe_i[req_space_i] : ss_reg;
   assign space_next = take_first ? req_space_i : space_reg;
   assign in_cycle_next = (state_next == ams_pkg::AMS_SETUP) || (state_next == ams_pkg::AMS_STROBE) ||
                          (state_next == ams_pkg::AMS_HOLD);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mem_chip_select_n_o <= '1;
         mem_direction_o <= 1'b1;
         mem_write_enable_n_o <= 1'b1;
         mem_output_enable_n_o <= 1'b1;
         mem_data_bus_oe_o <= 1'b0;
      end else begin
         mem_chip_select_n_o <= '1;
         if (ss_next ? (state_next == ams_pkg::AMS_STROBE) : in_cycle_next) begin
            mem_chip_select_n_o[space_next] <= 1'b0;
         end
         mem_direction_o <= !(write_next && in_cycle_next);
         mem_write_enable_n_o <= !(write_next && state_next == ams_pkg::AMS_STROBE);
         mem_output_enable_n_o <= !(!write_next && state_next == ams_pkg::AMS_STROBE);
         mem_data_bus_oe_o <= write_next && in_cycle_next;
      end
   end

   // Address and data change only when a beat is taken
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mem_address_out_o <= '0;
         mem_bank_address_out_o <= '0;
         mem_data_bus_o <= '0;
         mem_byte_enable_n_o <= '1;
      end else begin
         if (take_first) begin
            mem_address_out_o <= req_addr_i;
            mem_bank_address_out_o <= req_bank_i;
         end else if (take_next) begin
            mem_address_out_o <= mem_address_out_o + 21'h000001;
         end
         if (take_first || take_next) begin
            mem_data_bus_o <= req_wdata_i;
            mem_byte_enable_n_o <= req_be_n_i;
         end else if (!in_cycle_next) begin
            mem_byte_enable_n_o <= '1;
         end
      end
   end

   // ==========================================================
   // Read data: the capture flop is read only by the output flop
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         capture_reg <= '0;
         capture_valid_reg <= 1'b0;
         rd_data_o <= '0;
         rd_valid_o <= 1'b0;
      end else begin
         if (strobe_end && !write_reg) begin
            capture_reg <= mem_data_bus_i;
         end
         capture_valid_reg <= strobe_end && !write_reg;
         rd_data_o <= capture_reg;
         rd_valid_o <= capture_valid_reg;
      end
   end

   // ==========================================================
   // Checks
   property p_oe_write;
      @(posedge core_clk_i) disable iff (rst_i)
      (state_reg != ams_pkg::AMS_IDLE && state_reg != ams_pkg::AMS_TURN && write_reg) |-> mem_output_enable_n_o;
   endproperty
   a_oe_write: assert property (p_oe_write) else $error("output enable low during write");

   property p_read_pins;
      @(posedge core_clk_i) disable iff (rst_i)
      (state_reg == ams_pkg::AMS_STROBE && !write_reg) |-> (mem_write_enable_n_o && mem_direction_o && !mem_output_enable_n_o);
   endproperty
   a_read_pins: assert property (p_read_pins) else $error("read strobe pin levels wrong");

   property p_ss_select;
      @(posedge core_clk_i) disable iff (rst_i)
      (state_reg == ams_pkg::AMS_SETUP && ss_reg) |-> (&mem_chip_select_n_o);
   endproperty
   a_ss_select: assert property (p_ss_select) else $error("select active outside strobe");

   property p_normal_select;
      @(posedge core_clk_i) disable iff (rst_i)
      (state_reg == ams_pkg::AMS_SETUP && !ss_reg) |-> !mem_chip_select_n_o[space_reg];
   endproperty
   a_normal_select: assert property (p_normal_select) else $error("select not low in setup");

   property p_we_strobe;
      @(posedge core_clk_i) disable iff (rst_i)
      ($rose(state_reg == ams_pkg::AMS_STROBE) && write_reg) |-> !mem_write_enable_n_o ##1
      (!mem_write_enable_n_o || state_reg == ams_pkg::AMS_HOLD);
   endproperty
   a_we_strobe: assert property (p_we_strobe) else $error("write enable strobe wrong");

   property p_no_turn;
      @(posedge core_clk_i) disable iff (rst_i)
      (req_done_o && req_valid_i && req_write_i == write_reg) |=> (state_reg == ams_pkg::AMS_SETUP);
   endproperty
   a_no_turn: assert property (p_no_turn) else $error("turnaround inserted for same direction");

   property p_read_data;
      @(posedge core_clk_i) disable iff (rst_i)
      (strobe_end && !write_reg) |-> ##2 rd_valid_o;
   endproperty
   a_read_data: assert property (p_read_data) else $error("read data not delivered");

   property p_beat_counts;
      @(posedge core_clk_i) disable iff (rst_i)
      take_next |=> ($stable(strobe_reg) && $stable(hold_reg) && cnt_reg == ams_pkg::CNT_W'(setup_reg));
   endproperty
   a_beat_counts: assert property (p_beat_counts) else $error("counts reloaded on later beat");

   property p_timeout;
      @(posedge core_clk_i) disable iff (rst_i)
      timeout_o |-> (state_reg == ams_pkg::AMS_HOLD && $past(timeout_hit));
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout without expiry");

   property p_addr_stable;
      @(posedge core_clk_i) disable iff (rst_i)
      (state_reg == ams_pkg::AMS_STROBE || state_reg == ams_pkg::AMS_HOLD) |->
      ($stable(mem_address_out_o) && $stable(mem_data_bus_o) && $stable(mem_byte_enable_n_o));
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address or data moved in cycle");

endmodule // ams_sequencer
